// ### rtl/ssfep_tx.sv
// Secure SENT frame transmitter with error reporting and pause options.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Send position, rolling counter, inverted top nibble.
// - Order: sync, status, data, counter, inverse, CRC, pause.
// - Always-zero option clears status error bits except the bit0 repeat flag.
// - Standard option sets error bits on errors.
// - Error codes 4091, 4090, or 4095 alternately.
// - Out-of-range data sends the clamp value.
// - Error-code disable keeps sending measurement data.
// - Magnet-loss override sends substitute value instead.
// - Enabled pause pulse ends every frame.
// - Without pause, CRC end starts next sync.
// - Constant-frame mode sizes pause automatically.
// - Codes 1000-1111 select fixed tick frame lengths.
// - Codes 0001-0111 align frames to sample rate.
// - Repeated sample without pause sets status bit0.
// - CRC standard or legacy, status optionally included.
// - Slow channel bits can be switched off.
module ssfep_tx #(
  parameter int unsigned CLK_HZ_P = ssfep_pkg::CLK_HZ
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sample_valid,
  input wire ssfep_pkg::ssfep_sample_t sample,
  input wire logic [1:0] slow_bits,
  output logic slow_take,
  output logic frame_start,
  output logic sent_out
);
  import ssfep_pkg::*;

  localparam logic [20:0] PER_CYC [8] = '{
    21'(CLK_HZ_P / RATE_HZ[0]), 21'(CLK_HZ_P / RATE_HZ[1]),
    21'(CLK_HZ_P / RATE_HZ[2]), 21'(CLK_HZ_P / RATE_HZ[3]),
    21'(CLK_HZ_P / RATE_HZ[4]), 21'(CLK_HZ_P / RATE_HZ[5]),
    21'(CLK_HZ_P / RATE_HZ[6]), 21'(CLK_HZ_P / RATE_HZ[7])};

  logic acc;
  logic wr_q, wr_d;
  logic [7:0] wa_q, wa_d;
  logic [11:0] proto_q, proto_d;
  logic [3:0] frame_length_select_q, frame_length_select_d;
  logic [11:0] clo_q, clo_d, chi_q, chi_d, mag_q, mag_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic c_slow, c_errdis, c_stat, c_mag, c_pause, c_alt;
  ssfep_sample_t smp_q, smp_d;
  logic fresh_q, fresh_d;
  logic [6:0][3:0] nib_q, nib_d;
  logic [7:0] cnt_q, cnt_d;
  logic [11:0] pay_q, pay_d, pay, raw;
  logic esens, stat_err, rep;
  logic [3:0] crc_q;
  ssfep_state_t st_q, st_d;
  logic [9:0] pcnt_q, pcnt_d, tk_q, tk_d, len_q, len_d;
  logic [2:0] idx_q, idx_d, nidx;
  logic [20:0] fcyc_q, fcyc_d;
  logic out_q, out_d;
  logic snap, tick_end, pulse_end, rate_mode, pause_done;
  logic [9:0] used, total, constant_frame_pause;
  logic [7:0][3:0] all_nib;

  assign c_slow = proto_q[B_SLOW];
  assign c_errdis = proto_q[B_ERRDIS];
  assign c_stat = proto_q[B_STAT];
  assign c_mag = proto_q[B_MAG];
  assign c_pause = proto_q[B_PAUSE];
  assign c_alt = proto_q[B_ALT];
  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign sent_out = out_q;
  assign frame_start = snap;
  assign slow_take = snap && c_slow;

  // Bus slave: writes land in the data phase, reads see the next register value.
  always_comb begin
    acc = hsel && hready && htrans[1] && (hsize == SIZE_WORD);
    wr_d = acc && hwrite;
    wa_d = acc ? haddr[7:0] : wa_q;
    proto_d = proto_q;
    frame_length_select_d = frame_length_select_q;
    clo_d = clo_q;
    chi_d = chi_q;
    mag_d = mag_q;
    if (wr_q) begin
      case (wa_q)
        A_PROTO: proto_d = hwdata[11:0];
        A_OUT: frame_length_select_d = hwdata[3:0];
        A_CLAMP: begin
          clo_d = hwdata[11:0];
          chi_d = hwdata[CHI_LSB+:12];
        end
        A_MAG: mag_d = hwdata[11:0];
        default: ;
      endcase
    end
    hrdata_d = hrdata_q;
    if (acc && !hwrite) begin
      case (haddr[7:0])
        A_PROTO: hrdata_d = {20'h00000, proto_d};
        A_OUT: hrdata_d = {28'h0000000, frame_length_select_d};
        A_CLAMP: hrdata_d = {4'h0, chi_d, 4'h0, clo_d};
        A_MAG: hrdata_d = {20'h00000, mag_d};
        A_STAT: hrdata_d = {18'h00000, st_q == S_PAUSE, fresh_q, nib_q[0], cnt_q};
        default: hrdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      proto_q <= PROTO_RST;
      frame_length_select_q <= FSEL_RST;
      clo_q <= CLO_RST;
      chi_q <= CHI_RST;
      mag_q <= MAG_RST;
      hrdata_q <= 32'h00000000;
    end else begin
      wr_q <= wr_d;
      wa_q <= wa_d;
      proto_q <= proto_d;
      frame_length_select_q <= frame_length_select_d;
      clo_q <= clo_d;
      chi_q <= chi_d;
      mag_q <= mag_d;
      hrdata_q <= hrdata_d;
    end
  end

  // Frame content is frozen at the start of each frame.
  always_comb begin
    smp_d = sample_valid ? sample : smp_q;
    fresh_d = sample_valid ? 1'b1 : (snap ? 1'b0 : fresh_q);
    esens = smp_q.sens_err || (smp_q.mag_loss && !c_mag);
    raw = (smp_q.mag_loss && c_mag) ? mag_q : smp_q.pos;
    rep = !fresh_q && !c_pause;
    stat_err = c_stat && (esens || smp_q.func_err);
    if (!c_errdis && c_alt && esens) begin
      pay = ERR_ALT;
    end else if (!c_errdis && !c_alt && esens) begin
      pay = ERR_SENS;
    end else if (!c_errdis && !c_alt && smp_q.func_err) begin
      pay = ERR_FUNC;
    end else if (raw > chi_q) begin
      pay = chi_q;
    end else if (raw < clo_q) begin
      pay = clo_q;
    end else begin
      pay = raw;
    end
    nib_d = nib_q;
    cnt_d = cnt_q;
    pay_d = pay_q;
    if (snap) begin
      nib_d[0] = {c_slow ? slow_bits : 2'b00, stat_err, stat_err || rep};
      nib_d[1] = pay[11:8];
      nib_d[2] = pay[7:4];
      nib_d[3] = pay[3:0];
      nib_d[4] = cnt_q[7:4];
      nib_d[5] = cnt_q[3:0];
      nib_d[6] = ~pay[11:8];
      cnt_d = cnt_q + 8'h01;
      pay_d = pay;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      smp_q <= '0;
      fresh_q <= 1'b0;
      nib_q <= '0;
      cnt_q <= 8'h00;
      pay_q <= 12'h000;
    end else begin
      smp_q <= smp_d;
      fresh_q <= fresh_d;
      nib_q <= nib_d;
      cnt_q <= cnt_d;
      pay_q <= pay_d;
    end
  end

  ssfep_crc u_crc (
    .mclk(mclk),
    .reset(reset),
    .nibs(nib_q),
    .with_status(proto_q[B_CRCST]),
    .legacy(proto_q[B_LEGACY]),
    .crc_q(crc_q)
  );

  // Pulse engine: every pulse is low for up to LOW_TICKS ticks, then high for any ticks left.
  always_comb begin
    all_nib = {crc_q, nib_q};
    used = SYNC_TICKS;
    for (int i = 0; i < 8; i++) begin
      used = used + NIB_BASE + 10'(all_nib[i]);
    end
    total = FR_TICKS[frame_length_select_q[2:0]];
    constant_frame_pause = (total >= used + PAUSE_MIN) ? total - used : PAUSE_MIN;
    rate_mode = !frame_length_select_q[3] && (frame_length_select_q != 4'h0);
    tick_end = pcnt_q == TICK_LAST;
    pulse_end = tick_end && (tk_q == len_q - 10'h001);
    pause_done = rate_mode ? (fcyc_q >= PER_CYC[frame_length_select_q[2:0]] - 21'h000001)
                           : pulse_end;
    nidx = idx_q + 3'h1;
    st_d = st_q;
    idx_d = idx_q;
    len_d = len_q;
    pcnt_d = tick_end ? 10'h000 : pcnt_q + 10'h001;
    tk_d = (tick_end && tk_q != TK_MAX) ? tk_q + 10'h001 : tk_q;
    fcyc_d = fcyc_q + 21'h000001;
    snap = 1'b0;
    unique case (st_q)
      S_LOAD: snap = 1'b1;
      S_SYNC: begin
        if (pulse_end) begin
          st_d = S_NIB;
          idx_d = 3'h0;
          tk_d = 10'h000;
          len_d = NIB_BASE + 10'(nib_q[0]);
        end
      end
      S_NIB: begin
        if (pulse_end && idx_q == IDX_CRC) begin
          if (c_pause) begin
            st_d = S_PAUSE;
            tk_d = 10'h000;
            len_d = frame_length_select_q[3] ? constant_frame_pause : PAUSE_MIN;
          end else begin
            snap = 1'b1;
          end
        end else if (pulse_end) begin
          idx_d = nidx;
          tk_d = 10'h000;
          len_d = NIB_BASE + 10'(all_nib[nidx]);
        end
      end
      S_PAUSE: snap = pause_done;
    endcase
    if (snap) begin
      st_d = S_SYNC;
      pcnt_d = 10'h000;
      tk_d = 10'h000;
      len_d = SYNC_TICKS;
      fcyc_d = 21'h000000;
    end
    out_d = tk_d >= LOW_TICKS;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q <= S_LOAD;
      pcnt_q <= 10'h000;
      tk_q <= 10'h000;
      len_q <= SYNC_TICKS;
      idx_q <= 3'h0;
      fcyc_q <= 21'h000000;
      out_q <= 1'b1;
    end else begin
      st_q <= st_d;
      pcnt_q <= pcnt_d;
      tk_q <= tk_d;
      len_q <= len_d;
      idx_q <= idx_d;
      fcyc_q <= fcyc_d;
      out_q <= out_d;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  property p_secure;
    snap |=> nib_q[6] == ~nib_q[1] && {nib_q[4], nib_q[5]} == $past(cnt_q);
  endproperty
  a_secure: assert property (p_secure) else $error("secure nibbles wrong");
  property p_order;
    st_q == S_SYNC && pulse_end |=> st_q == S_NIB && len_q == NIB_BASE + 10'(nib_q[0]);
  endproperty
  a_order: assert property (p_order) else $error("status nibble not after sync");
  property p_zero;
    snap && !c_stat && !rep |=> nib_q[0][1:0] == 2'b00;
  endproperty
  a_zero: assert property (p_zero) else $error("status error bits not zero");
  property p_std;
    snap && c_stat && smp_q.func_err |=> nib_q[0][1:0] == 2'b11;
  endproperty
  a_std: assert property (p_std) else $error("status error bits not set");
  property p_code;
    snap && !c_errdis && !c_alt && smp_q.sens_err |=> pay_q == ERR_SENS;
  endproperty
  a_code: assert property (p_code) else $error("sensor error code missing");
  property p_clamp;
    snap && c_errdis && !smp_q.mag_loss && smp_q.pos > chi_q |=> pay_q == $past(chi_q);
  endproperty
  a_clamp: assert property (p_clamp) else $error("high clamp not applied");
  property p_errdis;
    snap && c_errdis && !smp_q.mag_loss && smp_q.pos <= chi_q && smp_q.pos >= clo_q
      |=> pay_q == $past(smp_q.pos);
  endproperty
  a_errdis: assert property (p_errdis) else $error("measurement not sent");
  property p_mag;
    snap && c_mag && smp_q.mag_loss && !smp_q.sens_err && !smp_q.func_err
      && mag_q <= chi_q && mag_q >= clo_q |=> pay_q == $past(mag_q) && !nib_q[0][1];
  endproperty
  a_mag: assert property (p_mag) else $error("magnet loss substitute wrong");
  property p_pause;
    st_q == S_NIB && idx_q == IDX_CRC && pulse_end && c_pause |=> st_q == S_PAUSE;
  endproperty
  a_pause: assert property (p_pause) else $error("pause pulse missing");
  property p_npp;
    st_q == S_NIB && idx_q == IDX_CRC && pulse_end && !c_pause
      |=> st_q == S_SYNC && tk_q == 10'h000 && !out_q;
  endproperty
  a_npp: assert property (p_npp) else $error("sync not right after CRC");
  property p_len;
    st_q == S_NIB && idx_q == IDX_CRC && pulse_end && c_pause && frame_length_select_q[3]
      && total >= used + PAUSE_MIN |=> len_q == $past(total) - $past(used);
  endproperty
  a_len: assert property (p_len) else $error("pause length wrong");
  property p_rep;
    snap && !c_pause && !fresh_q |=> nib_q[0][0];
  endproperty
  a_rep: assert property (p_rep) else $error("repeat flag missing");
  property p_cnt;
    snap |=> cnt_q == $past(cnt_q) + 8'h01;
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter did not step");
  c_pause_frame: cover property (st_q == S_PAUSE && snap);
  c_npp_repeat: cover property (snap && rep);
  c_err_frame: cover property (snap && esens && !c_errdis);
  c_rate_frame: cover property (snap && rate_mode && st_q == S_PAUSE);
endmodule
`default_nettype wire

// ### rtl/ssfep_pkg.sv
// Package with constants and types of the secure SENT frame transmitter.
package ssfep_pkg;
  localparam int unsigned CLK_NS = 5;
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned TICK_NS = 100;
  localparam int unsigned TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [9:0] TICK_LAST = 10'(TICK_CYC - 1);
  localparam logic [9:0] TK_MAX = 10'h3FF;
  localparam logic [9:0] SYNC_TICKS = 10'h038;
  localparam logic [9:0] LOW_TICKS = 10'h005;
  localparam logic [9:0] NIB_BASE = 10'h00C;
  localparam logic [9:0] PAUSE_MIN = 10'h001;
  localparam logic [2:0] IDX_CRC = 3'h7;
  localparam logic [3:0] CRC_SEED = 4'h5;
  localparam logic [3:0] CRC_POLY = 4'hD;
  localparam logic [11:0] ERR_SENS = 12'hFFB;
  localparam logic [11:0] ERR_FUNC = 12'hFFA;
  localparam logic [11:0] ERR_ALT = 12'hFFF;
  localparam logic [9:0] FR_TICKS [8] = '{10'h0E1, 10'h0EF, 10'h0FA, 10'h10D,
                                          10'h126, 10'h16E, 10'h177, 10'h1C2};
  localparam int unsigned RATE_HZ [8] = '{1, 4000, 2660, 2000, 1600, 1000, 800, 500};
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [7:0] A_PROTO = 8'h00;
  localparam logic [7:0] A_OUT = 8'h04;
  localparam logic [7:0] A_CLAMP = 8'h08;
  localparam logic [7:0] A_MAG = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam int B_SLOW = 4;
  localparam int B_ERRDIS = 5;
  localparam int B_STAT = 6;
  localparam int B_MAG = 7;
  localparam int B_PAUSE = 8;
  localparam int B_ALT = 9;
  localparam int B_CRCST = 10;
  localparam int B_LEGACY = 11;
  localparam int CHI_LSB = 16;
  localparam logic [11:0] PROTO_RST = 12'h140;
  localparam logic [3:0] FSEL_RST = 4'hC;
  localparam logic [11:0] CLO_RST = 12'h000;
  localparam logic [11:0] CHI_RST = 12'hFFF;
  localparam logic [11:0] MAG_RST = 12'h000;
  typedef struct packed {
    logic [11:0] pos;
    logic sens_err;
    logic func_err;
    logic mag_loss;
  } ssfep_sample_t;
  typedef enum logic [1:0] {S_LOAD, S_SYNC, S_NIB, S_PAUSE} ssfep_state_t;
endpackage

// ### rtl/ssfep_crc.sv
// Registered CRC nibble over the six data nibbles of a frame, plus the status nibble when with_status is set.
`timescale 1ns/10ps
`default_nettype none
module ssfep_crc (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [6:0][3:0] nibs,
  input wire logic with_status,
  input wire logic legacy,
  output logic [3:0] crc_q
);
  import ssfep_pkg::*;
  logic [3:0] crc_d;

  function automatic logic [3:0] crc_step(input logic [3:0] c, input logic [3:0] n);
    logic [3:0] x;
    x = c;
    for (int b = 0; b < 4; b++) begin
      x = x[3] ? ({x[2:0], 1'b0} ^ CRC_POLY) : {x[2:0], 1'b0};
    end
    return x ^ n;
  endfunction

  // The standard form ends with one extra zero nibble, the legacy form omits it.
  always_comb begin
    crc_d = CRC_SEED;
    if (with_status) begin
      crc_d = crc_step(crc_d, nibs[0]);
    end
    for (int i = 1; i < 7; i++) begin
      crc_d = crc_step(crc_d, nibs[i]);
    end
    if (!legacy) begin
      crc_d = crc_step(crc_d, 4'h0);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      crc_q <= 4'h0;
    end else begin
      crc_q <= crc_d;
    end
  end
endmodule
`default_nettype wire

// ### verif/ssfep_ecu_rx.sv
// Behavioural SENT receiver that decodes frames seen on the line.
`timescale 1ns/10ps
`default_nettype none
module ssfep_ecu_rx (
  input wire logic mclk,
  input wire logic reset,
  input wire logic sent_out,
  output logic [31:0] nibs,
  output int frames,
  output int len_ticks
);
  logic prev;
  int cnt, idx, tick, flen, r;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      prev = 1'b1;
      cnt = 0;
      idx = -1;
      tick = 1;
      flen = 0;
      frames = 0;
      len_ticks = 0;
      nibs = '0;
    end else begin
      cnt = cnt + 1;
      if (prev === 1'b1 && sent_out === 1'b0) begin
        r = (cnt + tick / 2) / tick;
        if (idx == 9 && r != 56) begin
          len_ticks = (flen + cnt + tick / 2) / tick;
          frames = frames + 1;
          idx = 0;
        end else if (idx == 9 || idx == 0) begin
          if (idx == 9) begin
            len_ticks = (flen + tick / 2) / tick;
            frames = frames + 1;
          end
          tick = cnt / 56;
          flen = cnt;
          idx = 1;
        end else if (idx > 0) begin
          nibs = {nibs[27:0], 4'(r - 12)};
          flen = flen + cnt;
          idx = idx + 1;
        end else begin
          idx = 0;
        end
        cnt = 0;
      end
      prev = sent_out;
    end
  end
endmodule
`default_nettype wire

// ### verif/ssfep_tx_tb.sv
// Self-checking bench for the secure SENT frame transmitter.
`timescale 1ns/10ps
`default_nettype none
module ssfep_tx_tb;
  import ssfep_pkg::*;
  logic mclk, reset, hsel, hwrite, sample_valid;
  logic [31:0] haddr, hwdata, hrdata, rd, nibs;
  logic [1:0] htrans, slow_bits;
  logic [2:0] hsize;
  logic hreadyout, hresp, slow_take, frame_start, sent_out;
  ssfep_sample_t sample;
  int frames, len_ticks, errors, check_count, fs_n, sl_n;
  ssfep_tx DUT (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sample_valid(sample_valid), .sample(sample), .slow_bits(slow_bits),
    .slow_take(slow_take), .frame_start(frame_start), .sent_out(sent_out));
  ssfep_ecu_rx ecu (.mclk(mclk), .reset(reset), .sent_out(sent_out),
    .nibs(nibs), .frames(frames), .len_ticks(len_ticks));
  always #2.5 mclk = ~mclk;
  // Counts frame starts and slow-channel hand-overs seen by the bench.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      fs_n <= 0;
      sl_n <= 0;
    end else begin
      if (frame_start === 1'b1) begin
        fs_n <= fs_n + 1;
      end
      if (slow_take === 1'b1) begin
        sl_n <= sl_n + 1;
      end
    end
  end
  task automatic end_of_test;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int k);
    int n;
    n = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1 || frames < k) begin
      n++;
      if (n > 20000) begin
        errors++;
        end_of_test();
      end
      @(posedge mclk);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= SIZE_WORD;
    wt(0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wt(0);
    rd = hrdata;
    chk(32'(hresp), 32'h0);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic give(input logic [11:0] p, input logic se, input logic ml);
    sample_valid <= 1'b1;
    sample <= '{p, se, 1'b0, ml};
    @(posedge mclk);
    sample_valid <= 1'b0;
  endtask
  function automatic logic [3:0] mulx(input logic [3:0] c);
    logic [7:0] v;
    v = {c, 4'h0};
    for (int b = 7; b >= 4; b--) begin
      if (v[b]) begin
        v = v ^ (8'h1D << (b - 4));
      end
    end
    return v[3:0];
  endfunction
  function automatic logic [31:0] fexp(input logic [3:0] st, input logic [11:0] p,
                                       input logic [7:0] c);
    logic [23:0] d;
    logic [3:0] r;
    d = {p, c, ~p[11:8]};
    r = CRC_SEED;
    for (int i = 5; i >= 0; i--) begin
      r = mulx(r) ^ d[i*4 +: 4];
    end
    return {st, d, mulx(r)};
  endfunction
  task automatic nplen;
    int s;
    s = 56;
    for (int i = 0; i < 8; i++) begin
      s = s + 12 + int'(nibs[i*4 +: 4]);
    end
    chk(32'(len_ticks), 32'(s));
  endtask
  // Register reset values and an unmapped read.
  task automatic t_regs;
    rchk(A_PROTO, 32'(PROTO_RST));
    rchk(A_OUT, 32'(FSEL_RST));
    rchk(A_CLAMP, {4'h0, CHI_RST, 4'h0, CLO_RST});
    rchk(A_MAG, 32'(MAG_RST));
    rchk(8'h20, 32'h0);
  endtask
  // First frame at the default constant length of 294 ticks.
  task automatic t_const;
    give(12'h800, 1'b1, 1'b0);
    wt(1);
    chk(nibs, fexp(4'h0, 12'h000, 8'h00));
    chk(32'(len_ticks), 32'(FR_TICKS[FSEL_RST[2:0]]));
  endtask
  // Sensor error replaces the payload and raises both status error bits.
  task automatic t_err;
    give(12'h800, 1'b0, 1'b0);
    wt(2);
    chk(nibs, fexp(4'h3, ERR_SENS, 8'h01));
    chk(32'(len_ticks), 32'h126);
  endtask
  // Clean sample, then no pause, high clamp and slow channel on.
  task automatic t_clamp;
    bus(1'b1, A_PROTO, 32'h050);
    bus(1'b1, A_CLAMP, 32'h01000000);
    rchk(A_CLAMP, 32'h01000000);
    wt(3);
    chk(nibs, fexp(4'h0, 12'h800, 8'h02));
  endtask
  // Repeated sample without pause, clamped payload.
  task automatic t_repeat;
    bus(1'b1, A_PROTO, 32'h080);
    bus(1'b1, A_MAG, 32'h0A5);
    give(12'h800, 1'b0, 1'b1);
    wt(4);
    chk(nibs, fexp(4'hD, 12'h100, 8'h03));
    nplen();
  endtask
  // Magnet loss override, then error-code disable with status forced zero.
  task automatic t_mag_dis;
    bus(1'b1, A_PROTO, 32'h020);
    bus(1'b1, A_CLAMP, 32'h0FFF0000);
    give(12'h0C3, 1'b1, 1'b0);
    wt(5);
    chk(nibs, fexp(4'h0, 12'h0A5, 8'h04));
    nplen();
    wt(6);
    chk(nibs, fexp(4'h0, 12'h0C3, 8'h05));
    nplen();
    chk(32'(fs_n), 32'h7);
    chk(32'(sl_n), 32'h1);
  endtask
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = SIZE_WORD;
    hwdata = '0;
    sample_valid = 1'b0;
    sample = '0;
    slow_bits = 2'h3;
    errors = 0;
    check_count = 0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_const();
    t_err();
    t_clamp();
    t_repeat();
    t_mag_dis();
    end_of_test();
  end
endmodule
`default_nettype wire
